// ===== pkg/psb_pkg.sv
package psb_pkg;

	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ          = 40_000_000;
	localparam int STEP_DELAY_US   = 100;
	localparam int STEP_DELAY_CYC  = (CLK_HZ / 1_000_000) * STEP_DELAY_US;

	// ==========================================================
	// Boot strap word
	localparam int          BOOT_WIDTH    = 16;
	localparam logic [15:0] BOOT_DEFAULT  = 16'h8018;
	localparam int          BOOT_PD_BIT_A = 6;
	localparam int          BOOT_PD_BIT_B = 7;

	// ==========================================================
	// Register map (plain port, word index)
	localparam logic [3:0] REG_CTRL      = 4'h0;
	localparam logic [3:0] REG_STATUS    = 4'h1;
	localparam logic [3:0] REG_BOOT_WORD = 4'h2;

	// Control fields
	localparam int CTRL_START_BIT = 0;
	// Status fields
	localparam int STAT_BUF_DIS_BIT  = 0;
	localparam int STAT_PHY_REL_BIT  = 1;
	localparam int STAT_SW_ON_BIT    = 2;
	localparam int STAT_APP_OK_BIT   = 3;
	localparam int STAT_CAPTURED_BIT = 4;
	localparam int STAT_PULLS_OFF_BIT = 5;

	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		PSB_HOLD,
		PSB_PREP,
		PSB_BUF_OFF,
		PSB_PHY_REL,
		PSB_SW_ON
	} psb_state_e;

	// Pin drive group: level and output enable
	typedef struct packed {
		logic level;
		logic oe;
	} psb_pin_s;

	// Register bus request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} psb_bus_s;

endpackage : psb_pkg

// ===== rtl/psb_sync.sv
module psb_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             reset,
	// Data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	// ==========================================================
	// Two-stage synchroniser; first stage feeds only the second
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end

endmodule : psb_sync

// ===== rtl/psb_delay.sv
module psb_delay #(
	parameter int CYCLES = 4000
) (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic reset,
	// Control
	input  wire logic start,
	output logic      done
);

	// ==========================================================
	// Down counter; done pulses one cycle when count expires
	logic [31:0] count;
	logic        busy;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count <= 32'h0000_0000;
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				count <= 32'(CYCLES - 1);
				busy  <= 1'b1;
			end else if (busy) begin
				if (count == 32'h0000_0000) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					count <= count - 32'h0000_0001;
				end
			end
		end
	end

endmodule : psb_delay

// ===== rtl/psb_sequencer.sv
// Overview of operation
// - Isolation switch control is low and undriven from reset, switch open.
// - Buffer disable line is low from reset, so boot buffers are enabled.
// - Buffers enabled means boot inputs carry the resistor-array value exactly.
// - Sixteen boot pins captured on rising edge of power-on reset.
// - Sequencer resets from push button or power manager reset.
// - Straps are read as plain logic low or high only.
// - Boot pins stay default except bits 6 and 7 get pull-downs.
// - Pulls on pins shared with first transceiver straps are turned off.
// - Pulls on pins shared with second transceiver straps are turned off.
// - First drive buffer disable high as output.
// - After 100 us drive transceiver reset release high.
// - After a further 100 us drive isolation switch high.
// - Application pin use allowed only after the switch is closed.
//
// Implementation choices: the register addresses and the address-and-strobe port.
module psb_sequencer #(
	parameter int DELAY_CYCLES = psb_pkg::STEP_DELAY_CYC
) (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       reset,
	// Board reset sources
	input  wire logic                       reset_button_n,
	input  wire logic                       power_on_reset_n,
	// Boot strap pins
	input  wire logic [15:0]                boot_strap_pins,
	output logic      [15:0]                boot_pull_down_en,
	output logic                            pulls_off_phy1,
	output logic                            pulls_off_phy2,
	// Sequenced pins
	output psb_pkg::psb_pin_s               buffer_ctrl_pin,
	output psb_pkg::psb_pin_s               phy_reset_pin,
	output psb_pkg::psb_pin_s               switch_ctrl_pin,
	output logic                            app_pins_enable,
	output logic                            board_reset,
	// Register port
	input  wire psb_pkg::psb_bus_s          bus,
	output logic      [31:0]                rdata
);

	// ==========================================================
	// Input synchronisers
	logic        button_n_s;
	logic        por_n_s;
	logic [15:0] boot_s;

	psb_sync #(.WIDTH(2)) u_rst_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.din     ({reset_button_n, power_on_reset_n}),
		.dout    ({button_n_s, por_n_s})
	);

	psb_sync #(.WIDTH(16)) u_boot_sync (
		.clk_sys (clk_sys),
		.reset   (reset),
		.din     (boot_strap_pins),
		.dout    (boot_s)
	);

	// ==========================================================
	// Board reset combine
	logic hold;
	logic por_n_d;
	logic por_rise;

	// Either source alone holds the whole board in reset
	assign hold     = !button_n_s || !por_n_s;
	assign por_rise = por_n_s && !por_n_d;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			por_n_d     <= 1'b0;
			board_reset <= 1'b1;
		end else begin
			por_n_d     <= por_n_s;
			board_reset <= hold;
		end
	end

	// ==========================================================
	// Boot word capture
	logic [15:0] boot_word;
	logic        captured;

	// Sampled while buffers still drive, so the array value wins
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			boot_word <= psb_pkg::BOOT_DEFAULT;
			captured  <= 1'b0;
		end else if (hold) begin
			captured <= 1'b0;
		end else if (por_rise && !captured) begin
			boot_word <= boot_s;
			captured  <= 1'b1;
		end
	end

	// ==========================================================
	// Sequencer
	psb_pkg::psb_state_e state;
	psb_pkg::psb_state_e next_state;
	logic                start_req;
	logic                delay_start;
	logic                delay_done;

	psb_delay #(.CYCLES(DELAY_CYCLES)) u_delay (
		.clk_sys (clk_sys),
		.reset   (reset),
		.start   (delay_start),
		.done    (delay_done)
	);

	always_comb begin
		next_state  = state;
		delay_start = 1'b0;
		case (state)
			psb_pkg::PSB_HOLD: begin
				if (captured && start_req) begin
					next_state = psb_pkg::PSB_PREP;
				end
			end
			psb_pkg::PSB_PREP: begin
				next_state  = psb_pkg::PSB_BUF_OFF;
				delay_start = 1'b1;
			end
			psb_pkg::PSB_BUF_OFF: begin
				if (delay_done) begin
					next_state  = psb_pkg::PSB_PHY_REL;
					delay_start = 1'b1;
				end
			end
			psb_pkg::PSB_PHY_REL: begin
				if (delay_done) begin
					next_state = psb_pkg::PSB_SW_ON;
				end
			end
			psb_pkg::PSB_SW_ON: begin
				next_state = psb_pkg::PSB_SW_ON;
			end
			default: begin
				next_state = psb_pkg::PSB_HOLD;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset || hold) begin
			state <= psb_pkg::PSB_HOLD;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Pin drive
	always_ff @(posedge clk_sys) begin
		if (reset || hold) begin
			// Undriven and low: external pull-downs keep switch open, buffers on
			switch_ctrl_pin <= '{level: 1'b0, oe: 1'b0};
			buffer_ctrl_pin <= '{level: 1'b0, oe: 1'b0};
			phy_reset_pin   <= '{level: 1'b0, oe: 1'b0};
			app_pins_enable <= 1'b0;
		end else begin
			if (next_state == psb_pkg::PSB_BUF_OFF) begin
				buffer_ctrl_pin <= '{level: 1'b1, oe: 1'b1};
			end
			if (next_state == psb_pkg::PSB_PHY_REL) begin
				// Transceivers latch their straps on this edge
				phy_reset_pin <= '{level: 1'b1, oe: 1'b1};
			end
			if (next_state == psb_pkg::PSB_SW_ON) begin
				switch_ctrl_pin <= '{level: 1'b1, oe: 1'b1};
			end
			// Held back one cycle past the switch closing
			app_pins_enable <= (state == psb_pkg::PSB_SW_ON);
		end
	end

	// ==========================================================
	// Pull resistor control
	always_ff @(posedge clk_sys) begin
		if (reset || hold) begin
			boot_pull_down_en <= 16'h0000;
			pulls_off_phy1    <= 1'b0;
			pulls_off_phy2    <= 1'b0;
		end else if (next_state == psb_pkg::PSB_PREP) begin
			// Bits 6 and 7 would float once buffers turn off
			boot_pull_down_en <= 16'h0000;
			boot_pull_down_en[psb_pkg::BOOT_PD_BIT_A] <= 1'b1;
			boot_pull_down_en[psb_pkg::BOOT_PD_BIT_B] <= 1'b1;
			pulls_off_phy1 <= 1'b1;
			pulls_off_phy2 <= 1'b1;
		end
	end

	// ==========================================================
	// Register port
	logic [31:0] status;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			start_req <= 1'b0;
		end else if (bus.wr && bus.addr == psb_pkg::REG_CTRL) begin
			start_req <= bus.wdata[psb_pkg::CTRL_START_BIT];
		end
	end

	always_comb begin
		status = 32'h0000_0000;
		status[psb_pkg::STAT_BUF_DIS_BIT]   = buffer_ctrl_pin.level;
		status[psb_pkg::STAT_PHY_REL_BIT]   = phy_reset_pin.level;
		status[psb_pkg::STAT_SW_ON_BIT]     = switch_ctrl_pin.level;
		status[psb_pkg::STAT_APP_OK_BIT]    = app_pins_enable;
		status[psb_pkg::STAT_CAPTURED_BIT]  = captured;
		status[psb_pkg::STAT_PULLS_OFF_BIT] = pulls_off_phy1;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (bus.rd) begin
			case (bus.addr)
				psb_pkg::REG_CTRL:      rdata <= {31'h0000_0000, start_req};
				psb_pkg::REG_STATUS:    rdata <= status;
				psb_pkg::REG_BOOT_WORD: rdata <= {16'h0000, boot_word};
				default:                rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// Step timing monitors
	// Counted on the pins themselves, so the wait checks do not lean on the delay unit
	logic [31:0] buf_off_age;
	logic [31:0] phy_rel_age;

	always_ff @(posedge clk_sys) begin
		if (reset || !buffer_ctrl_pin.level) begin
			buf_off_age <= 32'h0000_0000;
		end else if (!phy_reset_pin.level) begin
			buf_off_age <= buf_off_age + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || !phy_reset_pin.level) begin
			phy_rel_age <= 32'h0000_0000;
		end else if (!switch_ctrl_pin.level) begin
			phy_rel_age <= phy_rel_age + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Bring-up steps: prep entry from the state, then each step as seen on the pins
	sequence s_prep_entered;
		state == psb_pkg::PSB_PREP;
	endsequence

	sequence s_buf_disabled;
		$rose(buffer_ctrl_pin.level) && buffer_ctrl_pin.oe;
	endsequence

	sequence s_phy_released;
		$rose(phy_reset_pin.level) && phy_reset_pin.oe;
	endsequence

	sequence s_switch_closed;
		$rose(switch_ctrl_pin.level) && switch_ctrl_pin.oe;
	endsequence

	// ==========================================================
	// Checks
	a_switch_after_phy: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(switch_ctrl_pin.level) |-> phy_reset_pin.level && buffer_ctrl_pin.level)
		else $error("switch closed before transceiver release");

	a_phy_after_buf: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(phy_reset_pin.level) |-> buffer_ctrl_pin.level)
		else $error("transceiver released with buffers on");

	a_app_after_sw: assert property (@(posedge clk_sys) disable iff (reset)
		app_pins_enable |-> switch_ctrl_pin.level)
		else $error("application pins before switch closed");

	a_hold_pins_low: assert property (@(posedge clk_sys) disable iff (reset)
		hold |=> !switch_ctrl_pin.oe && !switch_ctrl_pin.level && !buffer_ctrl_pin.oe)
		else $error("control lines driven during reset");

	a_reset_follows: assert property (@(posedge clk_sys) disable iff (reset)
		hold |=> board_reset)
		else $error("board reset not raised");

	a_boot_capture: assert property (@(posedge clk_sys) disable iff (reset)
		(por_rise && !captured && !hold) |=> captured && boot_word == $past(boot_s))
		else $error("boot word not captured");

	a_pulls_set: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(buffer_ctrl_pin.level) |-> boot_pull_down_en == 16'h00C0 && pulls_off_phy2)
		else $error("pulls not set before buffer disable");

	a_buf_first: assert property (@(posedge clk_sys) disable iff (reset || hold)
		(state == psb_pkg::PSB_PREP) |=> buffer_ctrl_pin.level && buffer_ctrl_pin.oe
			&& !phy_reset_pin.level)
		else $error("buffers not disabled first");

	a_delay_bound: assert property (@(posedge clk_sys) disable iff (reset || hold)
		$rose(buffer_ctrl_pin.level) |-> !phy_reset_pin.level [*8])
		else $error("transceiver release too early");

	a_phy_wait_met: assert property (@(posedge clk_sys) disable iff (reset)
		s_phy_released |-> buf_off_age >= 32'(DELAY_CYCLES))
		else $error("transceiver released before wait ended");

	a_switch_wait_met: assert property (@(posedge clk_sys) disable iff (reset)
		s_switch_closed |-> phy_rel_age >= 32'(DELAY_CYCLES))
		else $error("switch closed before wait ended");

	a_steps_in_order: assert property (@(posedge clk_sys) disable iff (reset || hold)
		s_prep_entered ##1 s_buf_disabled |-> !phy_reset_pin.level && !switch_ctrl_pin.level)
		else $error("bring-up steps out of order");

	a_app_after_close: assert property (@(posedge clk_sys) disable iff (reset || hold)
		s_switch_closed |=> app_pins_enable)
		else $error("application pins not handed over");

	a_pulls_released: assert property (@(posedge clk_sys) disable iff (reset)
		s_phy_released |-> pulls_off_phy1 && pulls_off_phy2)
		else $error("pulls still on at transceiver release");

	a_boot_word_kept: assert property (@(posedge clk_sys) disable iff (reset)
		captured |=> $stable(boot_word))
		else $error("boot word changed after capture");

endmodule : psb_sequencer

// ===== test/psb_board_model.sv
module psb_board_model #(
	parameter logic [15:0] BOOT_VAL = 16'h9A18
) (
	// Clock
	input  wire logic              clk_sys,
	// Pins from the sequencer
	input  wire psb_pkg::psb_pin_s buf_pin,
	input  wire psb_pkg::psb_pin_s rst_pin,
	input  wire logic [15:0]       pd_en,
	input  wire logic              pulls1,
	input  wire logic              pulls2,
	// Strap bus and latched settings
	output logic      [15:0]       strap_bus,
	output logic      [4:0]        addr1,
	output logic      [4:0]        addr2,
	output logic      [5:0]        cfg1,
	output logic      [5:0]        cfg2
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Buffers and transceivers
	logic toggle = 1'b0;
	logic buf_on;
	logic phy_run;
	always @(posedge clk_sys) toggle <= ~toggle;
	// Enabled while the disable line is low or undriven
	assign buf_on = !(buf_pin.oe && buf_pin.level);
	// Released pins wander, so only a pull-down gives a valid level
	assign strap_bus = buf_on ? BOOT_VAL : ({16{toggle}} & ~pd_en);
	assign phy_run = rst_pin.oe && rst_pin.level;
	// Strap resistors: fiber, autoneg, energy efficient, fast link drop, refclk 50, link LED
	localparam logic [5:0] STRAP_CFG = 6'h11;
	// Straps taken at the moment reset lets go; buffers or processor pulls still on spoil them
	always @(posedge phy_run) begin
		if (buf_on) begin
			addr1 <= BOOT_VAL[4:0];
			addr2 <= BOOT_VAL[4:0];
			cfg1  <= BOOT_VAL[10:5];
			cfg2  <= BOOT_VAL[10:5];
		end else begin
			addr1 <= pulls1 ? 5'h01 : 5'h00;
			addr2 <= pulls2 ? 5'h0D : 5'h00;
			cfg1  <= pulls1 ? STRAP_CFG : 6'h00;
			cfg2  <= pulls2 ? STRAP_CFG : 6'h00;
		end
	end
endmodule : psb_board_model

// ===== test/test_psb_sequencer.sv
module test_psb_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Bench signals
	localparam int          DLY  = 10;
	localparam logic [15:0] BOOT = 16'h9A18;
	logic              clk_sys = 1'b0;
	logic              reset = 1'b1;
	logic              reset_button_n = 1'b1;
	logic              power_on_reset_n = 1'b0;
	logic [15:0]       pins;
	logic [15:0]       pd_en;
	logic              po1;
	logic              po2;
	psb_pkg::psb_pin_s bufp;
	psb_pkg::psb_pin_s phyp;
	psb_pkg::psb_pin_s swp;
	logic              app;
	logic              brst;
	psb_pkg::psb_bus_s bus = '0;
	logic [31:0]       rdata;
	logic [4:0]        a1;
	logic [4:0]        a2;
	logic [5:0]        c1;
	logic [5:0]        c2;
	logic [3:0]        ev;
	int                mismatches = 0;
	int                total_checks = 0;
	always #12.5 clk_sys = ~clk_sys;
	assign ev = {app, swp.oe & swp.level, phyp.oe & phyp.level, bufp.oe & bufp.level};
	psb_sequencer #(.DELAY_CYCLES(DLY)) u_psb_sequencer (
		.clk_sys(clk_sys), .reset(reset), .reset_button_n(reset_button_n),
		.power_on_reset_n(power_on_reset_n), .boot_strap_pins(pins),
		.boot_pull_down_en(pd_en), .pulls_off_phy1(po1), .pulls_off_phy2(po2),
		.buffer_ctrl_pin(bufp), .phy_reset_pin(phyp), .switch_ctrl_pin(swp),
		.app_pins_enable(app), .board_reset(brst), .bus(bus), .rdata(rdata));
	psb_board_model #(.BOOT_VAL(BOOT)) u_psb_board_model (
		.clk_sys(clk_sys), .buf_pin(bufp), .rst_pin(phyp), .pd_en(pd_en),
		.pulls1(po1), .pulls2(po2), .strap_bus(pins), .addr1(a1), .addr2(a2),
		.cfg1(c1), .cfg2(c2));
	// ==========================================
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys) bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_sys) bus.rd <= 1'b0;
		#1 d = rdata;
	endtask : rd
	task automatic wait_ev(input int b, output int n);
		n = 0;
		while (ev[b] !== 1'b1 && n < 300) begin
			@(posedge clk_sys);
			#1 n++;
		end
	endtask : wait_ev
	// ==========================================
	// Scenarios
	task automatic t_reset();
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		#1 check("pins idle", 6'h00, {bufp, phyp, swp});
		check("board reset", 1'b1, brst);
	endtask : t_reset
	task automatic t_capture();
		logic [31:0] d;
		repeat (3) @(posedge clk_sys);
		#1 check("reset from power", 1'b1, brst);
		@(posedge clk_sys) power_on_reset_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		rd(psb_pkg::REG_BOOT_WORD, d);
		check("boot word", {16'h0, BOOT}, d);
		rd(4'hF, d);
		check("unmapped", 32'h0, d);
		check("idle after capture", 6'h00, {bufp, phyp, swp});
	endtask : t_capture
	task automatic t_sequence();
		int n;
		logic [31:0] d;
		wr(psb_pkg::REG_CTRL, 32'h1);
		wait_ev(0, n);
		check("buffer off delay", 2, n);
		check("pulldowns", 16'h00C0, pd_en);
		check("pulls off", 2'b11, {po1, po2});
		check("phy still held", 1'b0, ev[1]);
		wait_ev(1, n);
		check("phy release delay", DLY + 1, n);
		check("switch still open", 1'b0, ev[2]);
		check("straps latched", {5'h01, 5'h0D}, {a1, a2});
		check("strap config", 12'h451, {c1, c2});
		wait_ev(2, n);
		check("switch delay", DLY + 1, n);
		wait_ev(3, n);
		check("app delay", 1, n);
		rd(psb_pkg::REG_STATUS, d);
		check("status", 32'h3F, d);
		rd(psb_pkg::REG_BOOT_WORD, d);
		check("boot word kept", {16'h0, BOOT}, d);
	endtask : t_sequence
	task automatic t_button();
		@(posedge clk_sys) reset_button_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1 check("button reset", 1'b1, brst);
		check("pins dropped", 7'h00, {bufp, phyp, swp, app});
		@(posedge clk_sys) reset_button_n <= 1'b1;
	endtask : t_button
	// ==========================================
	// Run control
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	initial begin
		t_reset();
		t_capture();
		t_sequence();
		t_button();
		results();
	end
	initial begin
		#(25 * 2000);
		mismatches++;
		results();
	end
endmodule : test_psb_sequencer
